/* hdl/vdb_decoder.sv */
// Purpose: depuncturer, K=7 Viterbi core and BER sync monitor
// Assumes: symbols come from logic on core_clk, no synchroniser
// Notes: register exchange survivors, oldest bit of best state out
`timescale 1ns/10ps
`default_nettype none
module vdb_decoder (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [vdb_pkg::VDB_AW-1:0] reg_addr,
	input wire logic [vdb_pkg::VDB_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [vdb_pkg::VDB_DW-1:0] reg_rdata,
	// Channel symbols
	input wire logic [2:0] symbol_input_a,
	input wire logic [2:0] symbol_input_b,
	input wire logic sym_valid,
	output logic sym_ready,
	// Decoded stream and status
	output logic dec_bit,
	output logic dec_valid,
	output logic in_sync,
	output logic irq
);
	import vdb_pkg::*;

	// ========================================
	// Functions
	function automatic logic [2:0] to_ofs(input logic [2:0] v,
		input logic sm);
		if (!sm) return v;
		return v[2] ? 3'h3 - {1'b0, v[1:0]} : 3'h4 + {1'b0, v[1:0]};
	endfunction
	function automatic logic [3:0] bmet(input logic [2:0] v,
		input logic e, input logic er);
		if (er) return 4'h0;
		return {1'b0, e ? 3'h7 - v : v};
	endfunction
	// Modular compare: metrics wrap, spread stays far below 512
	function automatic logic later(input logic [9:0] x,
		input logic [9:0] y);
		logic [9:0] d;
		d = x - y;
		return !d[9] && (d != 10'h0);
	endfunction
	function automatic logic [1:0] enc(input logic [6:0] r7);
		return {^(r7 & VDB_G0), ^(r7 & VDB_G1)};
	endfunction
	function automatic logic [2:0] cinc(input logic [2:0] c,
		input logic [2:0] len);
		return (c >= len - 3'h1) ? 3'h0 : c + 3'h1;
	endfunction

	// ========================================
	// State
	logic [5:0] mode_r, mode_nxt;
	logic [15:0] win_r, win_nxt, max_r, max_nxt, cnt_r, cnt_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic rdy_r, rdy_nxt, irq_r, irq_nxt;
	vdb_sync_e sync_r, sync_nxt;
	logic [1:0] rot_r, rot_nxt;
	logic [2:0] aln_r, aln_nxt;
	logic [2:0] q_r [4];
	logic [2:0] q_nxt [4];
	logic [2:0] qn_r, qn_nxt, col_r, col_nxt;
	logic rin_r, rin_nxt;
	logic [9:0] pm_r [VDB_NS];
	logic [9:0] pm_nxt [VDB_NS];
	logic [VDB_TB-1:0] pth_r [VDB_NS];
	logic [VDB_TB-1:0] pth_nxt [VDB_NS];
	vdb_col_s dl_r [VDB_TB];
	vdb_col_s dl_nxt [VDB_TB];
	logic [17:0] bits_r, bits_nxt, acc_r, acc_nxt, tot_err;
	logic [6:0] fill_r, fill_nxt;
	logic [5:0] renc_r, renc_nxt, best;
	logic dbit_r, dbit_nxt, dval_r, dval_nxt;
	vdb_col_s col_s;
	logic [2:0] rate;
	logic [1:0] col_err;
	logic step, chk, win_end, bad, slip;

	// ========================================
	// Depuncture and input queue
	// Queue holds 4 symbols; ready drops early so a push never overflows
	always_comb begin
		logic [2:0] ra, rb, len, rem;
		logic [2:0] t [6];
		logic [1:0] need, p;
		logic pa, pb, bpsk;
		bpsk = mode_r[VDB_M_BPSK];
		rate = mode_r[VDB_M_RATE+:3] > VDB_RATE_MAX ? 3'h0
			: mode_r[VDB_M_RATE+:3];
		len = VDB_PLEN[rate];
		pa = VDB_PAT_A[rate][col_r];
		pb = VDB_PAT_B[rate][col_r];
		need = {1'b0, pa} + {1'b0, pb};
		step = qn_r >= {1'b0, need};
		col_s.a = pa ? q_r[0] : 3'h0;
		col_s.ea = !pa;
		col_s.b = !pb ? 3'h0 : (pa ? q_r[1] : q_r[0]);
		col_s.eb = !pb;
		ra = to_ofs(symbol_input_a, mode_r[VDB_M_SM]);
		rb = to_ofs(symbol_input_b, mode_r[VDB_M_SM]);
		if (bpsk) begin
			ra = rot_r[1] ? ~ra : ra;
		end else begin
			unique case (rot_r)
				2'h0: ;
				2'h1: {ra, rb} = {~rb, ra};
				2'h2: {ra, rb} = {~ra, ~rb};
				2'h3: {ra, rb} = {rb, ~ra};
			endcase
		end
		p = step ? need : 2'h0;
		for (int k = 0; k < 6; k++) begin
			t[k] = 3'h0;
		end
		for (int k = 0; k < 4; k++) begin
			if (k + int'(p) < 4) t[k] = q_r[k+int'(p)];
		end
		rem = qn_r - {1'b0, p};
		qn_nxt = rem;
		if (sym_valid && rin_r) begin
			t[rem] = ra;
			qn_nxt = rem + 3'h1;
			if (!bpsk) begin
				t[rem+3'h1] = rb;
				qn_nxt = rem + 3'h2;
			end
		end
		for (int k = 0; k < 4; k++) begin
			q_nxt[k] = t[k];
		end
		rin_nxt = qn_nxt <= (bpsk ? 3'h3 : 3'h2);
		col_nxt = step ? cinc(col_r, len) : col_r;
		if (slip) col_nxt = cinc(col_nxt, len);
	end

	// ========================================
	// Viterbi core: add-compare-select and register exchange
	always_comb begin
		logic [6:0] r0, r1;
		logic [1:0] e0, e1;
		logic [9:0] m0, m1;
		best = 6'h0;
		for (int s = 1; s < VDB_NS; s++) begin
			if (later(pm_r[best], pm_r[s])) best = 6'(s);
		end
		for (int s = 0; s < VDB_NS; s++) begin
			r0 = {6'(s), 1'b0};
			r1 = {6'(s), 1'b1};
			e0 = enc(r0);
			e1 = enc(r1);
			m0 = pm_r[r0[5:0]] + 10'(bmet(col_s.a, e0[1], col_s.ea))
				+ 10'(bmet(col_s.b, e0[0], col_s.eb));
			m1 = pm_r[r1[5:0]] + 10'(bmet(col_s.a, e1[1], col_s.ea))
				+ 10'(bmet(col_s.b, e1[0], col_s.eb));
			pm_nxt[s] = pm_r[s];
			pth_nxt[s] = pth_r[s];
			if (step) begin
				if (later(m0, m1)) begin
					pm_nxt[s] = m1;
					pth_nxt[s] = {pth_r[r1[5:0]][VDB_TB-2:0], r1[6]};
				end else begin
					pm_nxt[s] = m0;
					pth_nxt[s] = {pth_r[r0[5:0]][VDB_TB-2:0], r0[6]};
				end
			end
		end
	end

	// ========================================
	// Delay line, re-encoder and BER window
	always_comb begin
		logic [6:0] r7;
		logic [1:0] e, ce, cb;
		logic [17:0] tb;
		logic dbit;
		vdb_col_s od;
		for (int i = 0; i < VDB_TB; i++) begin
			dl_nxt[i] = dl_r[i];
			if (step) dl_nxt[i] = (i == 0) ? col_s : dl_r[i-1];
		end
		od = dl_r[VDB_TB-1];
		chk = step && fill_r == VDB_FILL;
		fill_nxt = (step && fill_r != VDB_FILL) ? fill_r + 7'h1 : fill_r;
		dbit = pth_r[best][VDB_TB-1];
		r7 = {dbit, renc_r};
		e = enc(r7);
		ce = {1'b0, !od.ea && (e[1] != od.a[2])}
			+ {1'b0, !od.eb && (e[0] != od.b[2])};
		cb = {1'b0, !od.ea} + {1'b0, !od.eb};
		col_err = chk ? ce : 2'h0;
		tot_err = acc_r + 18'(col_err);
		tb = bits_r + 18'(chk ? cb : 2'h0);
		win_end = chk && tb >= {win_r, 2'h0};
		bad = tot_err[17:2] > max_r;
		dval_nxt = chk;
		dbit_nxt = chk ? dbit : dbit_r;
		renc_nxt = chk ? r7[6:1] : renc_r;
		acc_nxt = tot_err;
		bits_nxt = tb;
		cnt_nxt = cnt_r;
		sync_nxt = sync_r;
		rot_nxt = rot_r;
		aln_nxt = aln_r;
		slip = 1'b0;
		if (win_end) begin
			acc_nxt = 18'h0;
			bits_nxt = 18'h0;
			cnt_nxt = tot_err[17:2];
			if (bad) begin
				sync_nxt = VDB_HUNT;
				rot_nxt = rot_r + 2'h1;
				if (rot_r == 2'h3) begin
					slip = 1'b1;
					aln_nxt = aln_r + 3'h1;
				end
			end else begin
				sync_nxt = VDB_LOCK;
			end
		end
	end

	// ========================================
	// Registers seen by software
	always_comb begin
		mode_nxt = mode_r;
		win_nxt = win_r;
		max_nxt = max_r;
		rdy_nxt = rdy_r;
		rdata_nxt = 16'h0;
		if (reg_wr) begin
			case (reg_addr)
				VDB_A_MODE: mode_nxt = reg_wdata[5:0];
				VDB_A_STAT: if (reg_wdata[VDB_S_RDY]) rdy_nxt = 1'b0;
				VDB_A_WIN: win_nxt = reg_wdata;
				VDB_A_MAX: max_nxt = reg_wdata;
				default: ;
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		if (win_end) rdy_nxt = 1'b1;
		irq_nxt = rdy_r && mode_r[VDB_M_IRQ];
		if (reg_rd) begin
			case (reg_addr)
				VDB_A_MODE: rdata_nxt = {10'h0, mode_r};
				VDB_A_STAT: rdata_nxt = {9'h0, aln_r, rot_r,
					sync_r == VDB_LOCK, rdy_r};
				VDB_A_WIN: rdata_nxt = win_r;
				VDB_A_MAX: rdata_nxt = max_r;
				VDB_A_CNT: rdata_nxt = cnt_r;
				default: rdata_nxt = 16'h0;
			endcase
		end
	end

	// ========================================
	// Flip-flops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_r <= VDB_MODE_RST;
			win_r <= VDB_WIN_RST;
			max_r <= VDB_MAX_RST;
			cnt_r <= 16'h0;
			rdata_r <= 16'h0;
			rdy_r <= 1'b0;
			irq_r <= 1'b0;
			sync_r <= VDB_HUNT;
			rot_r <= 2'h0;
			aln_r <= 3'h0;
			qn_r <= 3'h0;
			col_r <= 3'h0;
			rin_r <= 1'b0;
			bits_r <= 18'h0;
			acc_r <= 18'h0;
			fill_r <= 7'h0;
			renc_r <= 6'h0;
			dbit_r <= 1'b0;
			dval_r <= 1'b0;
			for (int k = 0; k < 4; k++) q_r[k] <= 3'h0;
			for (int s = 0; s < VDB_NS; s++) begin
				pm_r[s] <= 10'h0;
				pth_r[s] <= '0;
			end
			for (int i = 0; i < VDB_TB; i++) dl_r[i] <= '0;
		end else begin
			mode_r <= mode_nxt;
			win_r <= win_nxt;
			max_r <= max_nxt;
			cnt_r <= cnt_nxt;
			rdata_r <= rdata_nxt;
			rdy_r <= rdy_nxt;
			irq_r <= irq_nxt;
			sync_r <= sync_nxt;
			rot_r <= rot_nxt;
			aln_r <= aln_nxt;
			qn_r <= qn_nxt;
			col_r <= col_nxt;
			rin_r <= rin_nxt;
			bits_r <= bits_nxt;
			acc_r <= acc_nxt;
			fill_r <= fill_nxt;
			renc_r <= renc_nxt;
			dbit_r <= dbit_nxt;
			dval_r <= dval_nxt;
			q_r <= q_nxt;
			pm_r <= pm_nxt;
			pth_r <= pth_nxt;
			dl_r <= dl_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign sym_ready = rin_r;
	assign dec_bit = dbit_r;
	assign dec_valid = dval_r;
	// Lock code bit of the one-hot sync state
	assign in_sync = sync_r[1];
	assign irq = irq_r;

	// ========================================
	// Assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_end_enabled;
		win_end && mode_r[VDB_M_IRQ] ##1 mode_r[VDB_M_IRQ];
	endsequence
	AST_RDY_SET: assert property (win_end |=> rdy_r)
		else $error("ready flag missed at window end");
	AST_CNT_XFER: assert property (
		win_end |=> cnt_r == $past(tot_err[17:2]))
		else $error("error count not errors over four");
	AST_CNT_HOLD: assert property (!win_end |=> $stable(cnt_r))
		else $error("error count moved inside a window");
	AST_ACC_CLR: assert property (
		win_end |=> acc_r == 18'h0 && bits_r == 18'h0)
		else $error("window did not restart cleanly");
	AST_IRQ_CHAIN: assert property (s_end_enabled |=> irq_r)
		else $error("interrupt missing for enabled ready");
	AST_IRQ_MASK: assert property (!mode_r[VDB_M_IRQ] |=> !irq_r)
		else $error("interrupt with enable clear");
	AST_ERASE_SKIP: assert property (chk && dl_r[VDB_TB-1].ea
		&& dl_r[VDB_TB-1].eb |-> col_err == 2'h0)
		else $error("erased symbol counted as error");
	AST_PUNCT: assert property (step |-> col_s.ea
		== !VDB_PAT_A[rate][col_r] && col_s.eb
		== !VDB_PAT_B[rate][col_r])
		else $error("erasure not at punctured position");
	AST_SYNC_STEP: assert property (win_end && bad
		|=> rot_r == $past(rot_r) + 2'h1 && !in_sync)
		else $error("no phase step after bad window");
endmodule
`default_nettype wire

/* shared/vdb_pkg.sv */
// Purpose: constants and types of the Viterbi decoder with BER monitor
// Assumes: one 100 MHz clock, plain register port, symbols same clock
// Notes: register offsets are word indices on the register port
// Operation
// - K=7 rate 1/2 code, taps 171, 133
// - Maximum-likelihood decoding, serial decoded bit output
// - Survivor memory 96 deep for all rates
// - Symbols are 3-bit 8-level soft decisions
// - Offset binary or sign magnitude, selectable
// - Rates 1/2 to 7/8 via depuncturing
// - Patterns for rates 1/2, 2/3, 3/4
// - Patterns for rates 5/6 and 7/8
// - Depuncture reorders symbols, inserts erasures
// - Delayed input versus re-encoded output flags errors
// - Erased positions never count as errors
// - Window spans window length times 4 bits
// - Count transferred once per window, ready flagged
// - Readable count is errors divided by 4
// - Window end sets ready flag in status
// - Interrupt only when irq enable set
// - Too many errors steps rotation; alignment steps when rotation wraps from 3
`default_nettype none
package vdb_pkg;
	// ========================================
	// Register port
	localparam int VDB_AW = 3;
	localparam int VDB_DW = 16;
	localparam logic [2:0] VDB_A_MODE = 3'h0;
	localparam logic [2:0] VDB_A_STAT = 3'h1;
	localparam logic [2:0] VDB_A_WIN = 3'h2;
	localparam logic [2:0] VDB_A_MAX = 3'h3;
	localparam logic [2:0] VDB_A_CNT = 3'h4;
	// Mode fields: irq enable, sign magnitude, BPSK, rate [5:3]
	localparam int VDB_M_IRQ = 0;
	localparam int VDB_M_SM = 1;
	localparam int VDB_M_BPSK = 2;
	localparam int VDB_M_RATE = 3;
	// Status fields: ready, in sync, rotation [3:2], alignment [6:4]
	localparam int VDB_S_RDY = 0;
	localparam int VDB_S_SYNC = 1;
	localparam int VDB_S_ROT = 2;
	localparam int VDB_S_ALN = 4;
	localparam logic [5:0] VDB_MODE_RST = 6'h00;
	localparam logic [15:0] VDB_WIN_RST = 16'h0100;
	localparam logic [15:0] VDB_MAX_RST = 16'h003d;
	// ========================================
	// Code and trellis
	localparam logic [6:0] VDB_G0 = 7'h79;
	localparam logic [6:0] VDB_G1 = 7'h5b;
	localparam int VDB_NS = 64;
	localparam int VDB_TB = 96;
	localparam logic [6:0] VDB_FILL = 7'h60;
	localparam logic [2:0] VDB_RATE_MAX = 3'h4;
	// Puncture masks, bit j is column j; index is rate code 0..4
	localparam logic [4:0][6:0] VDB_PAT_A =
		{7'h51, 7'h15, 7'h05, 7'h01, 7'h01};
	localparam logic [4:0][6:0] VDB_PAT_B =
		{7'h2f, 7'h0b, 7'h03, 7'h03, 7'h01};
	localparam logic [4:0][2:0] VDB_PLEN =
		{3'h7, 3'h5, 3'h3, 3'h2, 3'h1};
	// ========================================
	// Types
	typedef struct packed {
		logic [2:0] a;
		logic [2:0] b;
		logic ea;
		logic eb;
	} vdb_col_s;
	typedef enum logic [1:0] {
		VDB_HUNT = 2'b01,
		VDB_LOCK = 2'b10
	} vdb_sync_e;
endpackage
`default_nettype wire

/* tb/vdb_demod_model.sv */
// Purpose: demodulator model feeding punctured soft symbols
// Assumes: same clock as the decoder, offers change after a rising edge
// Notes: newest bit sits at the encoder MSB; flips emulate channel errors
`timescale 1ns/10ps
`default_nettype none
module vdb_demod_model
	import vdb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Stream setup
	input wire logic run,
	input wire logic [2:0] rate,
	input wire logic bpsk,
	input wire logic sm,
	input wire logic [5:0] flip_per,
	// Symbol port
	output logic [2:0] symbol_input_a,
	output logic [2:0] symbol_input_b,
	output logic sym_valid,
	input wire logic sym_ready,
	output int cols
);
	bit q[$];
	logic [5:0] st;
	logic [6:0] sr;
	int nsym, ncol, need, r, j;
	function automatic bit src_bit(input int k);
		return ^((32'(k) * 32'h9e3779b1) & 32'h000ff000);
	endfunction
	function automatic logic [2:0] lvl(input bit b);
		return sm ? (b ? 3'h3 : 3'h7) : (b ? 3'h7 : 3'h0);
	endfunction
	// ========================================
	// Encoder, puncturer and symbol offer
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q.delete();
			st = 6'h00;
			nsym = 0;
			ncol = 0;
			sym_valid <= 1'b0;
			symbol_input_a <= 3'h0;
			symbol_input_b <= 3'h0;
			cols <= 0;
		end else begin
			need = bpsk ? 1 : 2;
			if (sym_valid && sym_ready)
				repeat (need) void'(q.pop_front());
			r = (rate > VDB_RATE_MAX) ? 0 : int'(rate);
			// Whole columns only, so a pair may straddle two columns
			while (run && q.size() < need) begin
				sr = {src_bit(ncol), st};
				st = sr[6:1];
				j = ncol % int'(VDB_PLEN[r]);
				if (VDB_PAT_A[r][j]) begin
					nsym++;
					q.push_back(^(sr & VDB_G0)
						^ (flip_per != 6'h00 && nsym % flip_per == 0));
				end
				if (VDB_PAT_B[r][j]) begin
					nsym++;
					q.push_back(^(sr & VDB_G1)
						^ (flip_per != 6'h00 && nsym % flip_per == 0));
				end
				ncol++;
			end
			// Idle lines toggle so a stale value is never mistaken for data
			sym_valid <= q.size() >= need;
			symbol_input_a <= (q.size() >= need) ? lvl(q[0]) : ~symbol_input_a;
			symbol_input_b <= (q.size() >= 2 && !bpsk) ? lvl(q[1])
				: ~symbol_input_b;
			cols <= ncol;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the Viterbi decoder and BER monitor
// Assumes: demodulator model on the symbol port, clean unless flips set
// Notes: first 8 decoded bits are skipped while the trellis settles
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import vdb_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [VDB_AW-1:0] reg_addr = 3'h0;
	logic [VDB_DW-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [VDB_DW-1:0] reg_rdata, rd;
	logic [2:0] sym_a, sym_b;
	logic sym_valid, sym_ready, dec_bit, dec_valid, in_sync, irq;
	logic run = 1'b0;
	logic [2:0] rate = 3'h0;
	logic bpsk = 1'b0;
	logic sm = 1'b0;
	logic [5:0] flip_per = 6'h00;
	int cols, ndec, nbad, num_errors, total_checks;
	logic [15:0] dflt [6] = '{16'h0000, 16'h0000, VDB_WIN_RST, VDB_MAX_RST,
		16'h0000, 16'h0000};
	always #5 core_clk = ~core_clk;
	vdb_decoder vdb_decoder_inst (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .symbol_input_a(sym_a),
		.symbol_input_b(sym_b), .sym_valid(sym_valid), .sym_ready(sym_ready),
		.dec_bit(dec_bit), .dec_valid(dec_valid), .in_sync(in_sync), .irq(irq));
	vdb_demod_model vdb_demod_model_inst (.core_clk(core_clk), .rst(rst),
		.run(run), .rate(rate), .bpsk(bpsk), .sm(sm), .flip_per(flip_per),
		.symbol_input_a(sym_a), .symbol_input_b(sym_b), .sym_valid(sym_valid),
		.sym_ready(sym_ready), .cols(cols));
	// ========================================
	// Decoded stream monitor
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ndec = 0;
			nbad = 0;
		end else if (dec_valid === 1'b1) begin
			if (ndec >= 8 && dec_bit !== vdb_demod_model_inst.src_bit(ndec))
				nbad++;
			ndec++;
		end
	end
	// ========================================
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdreg(input logic [2:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
	endtask
	// Bounded feed: a stalled stream ends the run
	task automatic feed(input int n);
		run <= 1'b1;
		for (int i = 0; i < 50 * n && cols < n; i++)
			@(posedge core_clk);
		run <= 1'b0;
		if (cols < n) begin
			chk(16'h0000, 16'h0001, "stream stalled");
			end_of_test();
		end
	endtask
	// ========================================
	// Main sequence
	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) begin
			rdreg(3'(i));
			chk(rd, dflt[i], "reset value");
		end
		wr(VDB_A_CNT, 16'hffff);
		wr(3'h5, 16'hffff);
		rdreg(VDB_A_CNT);
		chk(rd, 16'h0000, "count read-only");
		rdreg(3'h5);
		chk(rd, 16'h0000, "unmapped read");
		$display("register test done");
		for (int i = 0; i < 7; i++) begin
			rate <= (i < 5) ? 3'(i) : 3'h0;
			bpsk <= (i == 5);
			sm <= (i == 6);
			do_reset();
			wr(VDB_A_WIN, 16'h0002);
			wr(VDB_A_MODE, {10'h000, rate, bpsk, sm, 1'b0});
			feed(400);
			for (int k = 0; k < 200 && ndec != cols - 96; k++)
				@(posedge core_clk);
			if (rate == 3'h0)
				chk(16'(ndec), 16'(cols - 96), "decoded count");
			chk(16'(nbad), 16'h0000, "decoded bits");
			rdreg(VDB_A_CNT);
			chk(rd, 16'h0000, "clean error count");
			rdreg(VDB_A_STAT);
			chk({15'h0000, rd[VDB_S_SYNC]}, 16'h0001, "sync");
			$display("config %0d done", i);
		end
		// One flip every 32 symbols: 8 per 256-bit window, count 2
		rate <= 3'h0;
		bpsk <= 1'b0;
		sm <= 1'b0;
		flip_per <= 6'h20;
		do_reset();
		wr(VDB_A_WIN, 16'h0040);
		feed(1000);
		rdreg(VDB_A_CNT);
		chk(rd, 16'h0002, "error count");
		chk(16'(nbad), 16'h0000, "corrected bits");
		rdreg(VDB_A_STAT);
		chk({15'h0000, rd[VDB_S_RDY]}, 16'h0001, "ready flag");
		chk({15'h0000, irq}, 16'h0000, "irq masked");
		wr(VDB_A_MODE, 16'h0001);
		repeat (2) @(posedge core_clk);
		#1 chk({15'h0000, irq}, 16'h0001, "irq enabled");
		wr(VDB_A_STAT, 16'h0001);
		rdreg(VDB_A_STAT);
		chk({15'h0000, rd[VDB_S_RDY]}, 16'h0000, "ready cleared");
		chk({15'h0000, irq}, 16'h0000, "irq follows flag");
		$display("error count test done");
		wr(VDB_A_MAX, 16'h0001);
		feed(cols + 300);
		rdreg(VDB_A_STAT);
		chk({15'h0000, rd[VDB_S_SYNC]}, 16'h0000, "sync lost");
		chk({15'h0000, rd[6:2] != 5'h00}, 16'h0001, "rotation");
		chk({15'h0000, in_sync}, 16'h0000, "sync pin");
		$display("sync loss test done");
		end_of_test();
	end
endmodule
`default_nettype wire
